// >>> rtl/fwp_pkg.sv
// status, write-protect and power-up constants of the serial flash control block.
// assumes a 100 MHz control clock; the serial clock side runs only while a frame is open.
package fwp_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 100;
	// durations below are plain defaults, shortened by top parameters in simulation
	localparam int unsigned T_PWR_INH_US = 1000;
	localparam int unsigned T_STAT_WR_US = 5000;
	localparam int unsigned T_PAGE_US = 700;
	localparam int unsigned T_SECT_US = 50000;
	localparam int unsigned T_BLK_US = 200000;
	localparam int unsigned T_CHIP_US = 2000000;
	localparam int unsigned PWR_INH_CYC = T_PWR_INH_US * CLK_MHZ;
	localparam int unsigned STAT_WR_CYC = T_STAT_WR_US * CLK_MHZ;
	localparam int unsigned PAGE_CYC = T_PAGE_US * CLK_MHZ;
	localparam int unsigned SECT_CYC = T_SECT_US * CLK_MHZ;
	localparam int unsigned BLK_CYC = T_BLK_US * CLK_MHZ;
	localparam int unsigned CHIP_CYC = T_CHIP_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// instruction codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_STAT_RD = 8'h05;
	localparam logic [7:0] OP_WR_ALLOW = 8'h06;
	localparam logic [7:0] OP_WR_DENY = 8'h04;
	localparam logic [7:0] OP_STAT_WR = 8'h01;
	localparam logic [7:0] OP_PAGE_WR = 8'h02;
	localparam logic [7:0] OP_SECT_WIPE = 8'h20;
	localparam logic [7:0] OP_BLK32_WIPE = 8'h52;
	localparam logic [7:0] OP_BLK64_WIPE = 8'hd8;
	localparam logic [7:0] OP_CHIP_WIPE_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_WIPE_B = 8'h60;
	localparam logic [7:0] OP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_WAKE = 8'hab;

	// ----------------------------------------------------------------
	// frame lengths and capture points in bits
	// ----------------------------------------------------------------
	localparam logic [15:0] LEN_OP = 16'h0008;
	localparam logic [15:0] LEN_STAT_WR = 16'h0010;
	localparam logic [15:0] LEN_ADDR = 16'h0020;
	localparam logic [15:0] LEN_PAGE_WR = 16'h0028;
	localparam logic [15:0] CAP_OP = 16'h0007;
	localparam logic [15:0] CAP_STAT = 16'h000f;
	localparam logic [15:0] CAP_ADDR = 16'h001f;
	localparam logic [15:0] CAP_DATA = 16'h0027;

	// ----------------------------------------------------------------
	// status_control layout and reset values
	// ----------------------------------------------------------------
	localparam int unsigned SB_BUSY = 0;
	localparam int unsigned SB_LATCH = 1;
	localparam int unsigned SB_PROT_LO = 2;
	localparam int unsigned SB_PROT_HI = 4;
	localparam int unsigned SB_LOCK = 7;
	localparam logic [2:0] PROT_RST = 3'h0;
	localparam logic LOCK_RST = 1'b0;

	// ----------------------------------------------------------------
	// protected ranges (upper limit, lower end is zero) and region masks
	// ----------------------------------------------------------------
	localparam logic [23:0] LIM_P1 = 24'h0fdfff;
	localparam logic [23:0] LIM_P2 = 24'h0fbfff;
	localparam logic [23:0] LIM_P3 = 24'h0f7fff;
	localparam logic [23:0] LIM_P4 = 24'h0effff;
	localparam logic [23:0] LIM_P5 = 24'h0dffff;
	localparam logic [23:0] LIM_P6 = 24'h0bffff;
	localparam logic [23:0] LIM_P7 = 24'hffffff;
	localparam logic [23:0] MASK_PAGE = 24'hffff00;
	localparam logic [23:0] MASK_SECT = 24'hfff000;
	localparam logic [23:0] MASK_BLK32 = 24'hff8000;
	localparam logic [23:0] MASK_BLK64 = 24'hff0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		AOP_NONE = 3'h0,
		AOP_PAGE = 3'h1,
		AOP_SECT = 3'h2,
		AOP_BLK32 = 3'h3,
		AOP_BLK64 = 3'h4,
		AOP_CHIP = 3'h5
	} fwp_aop_t;

	typedef enum logic [2:0] {
		ST_READY = 3'b001,
		ST_BUSY = 3'b010,
		ST_SLEEP = 3'b100
	} fwp_state_t;

	typedef struct packed {
		logic [7:0] op;
		logic [23:0] addr;
		logic [7:0] data;
		logic [15:0] bits;
	} fwp_frame_t;

	typedef struct packed {
		fwp_aop_t op;
		logic [23:0] addr;
		logic [7:0] data;
	} fwp_areq_t;

endpackage

// >>> rtl/fwp_link.sv
// serial-clock side: shifts in one frame, holds its fields, shifts status out.
// assumes sck edges while cs_n is high are ignored; held fields stay stable until the next frame's first edge.
module fwp_link import fwp_pkg::*; (
	// link pins
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic nrst,
	// status from the control clock domain, bit 8 is the sleep flag
	input wire logic [8:0] stat_in,
	// captured frame and frame toggle
	output fwp_frame_t frame,
	output logic frm_tgl,
	// serial output
	output logic so,
	output logic so_oe
);

	logic frm_rst_n;
	logic in_frame_r, in_frame_nxt;
	fwp_frame_t frame_r, frame_nxt;
	logic [31:0] sh_r, sh_nxt;
	logic tgl_r, tgl_nxt;
	logic [8:0] stat_s1_r, stat_s2_r, stat_s3_r, stat_ok_r, stat_ok_nxt;
	logic so_r, so_nxt, so_oe_r, so_oe_nxt;
	logic [15:0] cnt_cur;

	// deselect closes the frame at once, no sck edge needed
	assign frm_rst_n = nrst & ~cs_n;

	// ----------------------------------------------------------------
	// input capture on rising edges
	// ----------------------------------------------------------------
	always_comb begin
		in_frame_nxt = 1'b1;
		cnt_cur = in_frame_r ? frame_r.bits : 16'h0000;
		sh_nxt = {sh_r[30:0], si};
		frame_nxt = frame_r;
		// saturates; a very long status read stops repeating after 65535 bits
		frame_nxt.bits = (cnt_cur == 16'hffff) ? cnt_cur : cnt_cur + 16'h0001;
		tgl_nxt = in_frame_r ? tgl_r : ~tgl_r;
		// a status bit moves once the second and third stages agree
		stat_ok_nxt = ((stat_s2_r ~^ stat_s3_r) & stat_s3_r) | ((stat_s2_r ^ stat_s3_r) & stat_ok_r);
		if (cnt_cur == CAP_OP) begin
			frame_nxt.op = sh_nxt[7:0];
		end
		if (cnt_cur == CAP_ADDR) begin
			frame_nxt.addr = sh_nxt[23:0];
		end
		if ((cnt_cur == CAP_STAT && frame_r.op == OP_STAT_WR) || cnt_cur == CAP_DATA) begin
			frame_nxt.data = sh_nxt[7:0];
		end
	end

	always_ff @(posedge sck or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			in_frame_r <= 1'b0;
		end else begin
			in_frame_r <= in_frame_nxt;
		end
	end

	always_ff @(posedge sck or negedge nrst) begin
		if (!nrst) begin
			frame_r <= '0;
			sh_r <= 32'h00000000;
			tgl_r <= 1'b0;
			stat_s1_r <= 9'h000;
			stat_s2_r <= 9'h000;
			stat_s3_r <= 9'h000;
			stat_ok_r <= 9'h000;
		end else if (!cs_n) begin
			// edges while deselected, e.g. an idle-level change, must not disturb the frame
			frame_r <= frame_nxt;
			sh_r <= sh_nxt;
			tgl_r <= tgl_nxt;
			// bits may tear if status changes mid-read; the next byte repeats it cleanly
			stat_s1_r <= stat_in;
			stat_s2_r <= stat_s1_r;
			stat_s3_r <= stat_s2_r;
			stat_ok_r <= stat_ok_nxt;
		end
	end

	// ----------------------------------------------------------------
	// status output on falling edges, msb first, repeating
	// ----------------------------------------------------------------
	always_comb begin
		so_oe_nxt = in_frame_r && frame_r.op == OP_STAT_RD && frame_r.bits >= LEN_OP && !stat_ok_r[8];
		so_nxt = stat_ok_r[3'h7 - frame_r.bits[2:0]];
	end

	always_ff @(negedge sck or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else begin
			so_r <= so_nxt;
			so_oe_r <= so_oe_nxt;
		end
	end

	assign frame = frame_r;
	assign frm_tgl = tgl_r;
	assign so = so_r;
	assign so_oe = so_oe_r;

endmodule

// >>> rtl/fwp_status_ctl.sv
// status and write-protect control of a serial nor flash, top level.
// assumes NRST is held low while supply is below the write threshold;
// the array itself sits outside and takes ARRAY_REQ/ARRAY_CMD.
//
// Contract
// - busy flag, status bit 0, is 1 during program, erase or status write.
// - while busy, only the status read instruction is served.
// - busy clears to 0 when the operation completes.
// - write latch flag, status bit 1, sets after the write-allow instruction.
// - write latch clears at power-up, write-deny, and after any program/erase/status write.
// - three range-protect bits at 4:2 are non-volatile, status-writable, reset to zero.
// - lock bit 1 with write-guard low makes protect bits read-only, refuses status write.
// - a status write never changes busy or write latch bits.
// - write-allow must precede status write before non-volatile bits change.
// - write, program and erase frames not ending on a byte boundary are ignored.
// - after power-up, write commands are refused until the inhibit delay expires.
// - program, erase and status write are refused while the write latch is 0.
// - in deep sleep, every command except wake is ignored.
// - protect 000 none; 001/010/011 guard up to 0fdfff/0fbfff/0f7fff.
// - protect 100/101/110 guard up to 0effff/0dffff/0bffff; 111 guards all.
// - page program passes one data byte, the first after the address, within one page, 1 to 0 only.
// - erase sets the region to ff, then the internal erase cycle runs.
// - while held in power reset, nothing operates and no command is seen.
// - with lock bit 0 the write-guard pin is ignored for status writes.
// - inputs sampled on rising, outputs driven on falling serial clock edges.
module fwp_status_ctl import fwp_pkg::*; #(
	parameter int unsigned PWR_INH_CYCLES = PWR_INH_CYC,
	parameter int unsigned STAT_WR_CYCLES = STAT_WR_CYC,
	parameter int unsigned PAGE_CYCLES = PAGE_CYC,
	parameter int unsigned SECT_CYCLES = SECT_CYC,
	parameter int unsigned BLK_CYCLES = BLK_CYC,
	parameter int unsigned CHIP_CYCLES = CHIP_CYC
) (
	// control clock and power reset
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic CE,
	// serial link
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic SI,
	input wire logic WG_N,
	output logic SO,
	output logic SO_OE,
	// array operation request
	output logic ARRAY_REQ,
	output fwp_areq_t ARRAY_CMD
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	fwp_frame_t frame;
	logic frm_tgl;
	logic [2:0] sync1_r, sync2_r, sync3_r, agreed_r, agreed_nxt;
	logic cs_prev_r, cs_prev_nxt;
	logic tgl_seen_r, tgl_seen_nxt;
	logic frame_end;
	logic cs_q, tgl_q, wg_q;
	fwp_state_t state_r, state_nxt;
	logic latch_r, latch_nxt;
	logic lock_r, lock_nxt;
	logic [2:0] prot_r, prot_nxt;
	logic [31:0] busy_cnt_r, busy_cnt_nxt;
	logic [31:0] inh_cnt_r, inh_cnt_nxt;
	logic inh_done_r, inh_done_nxt;
	logic [8:0] stat_vec_r, stat_vec_nxt;
	logic areq_r, areq_nxt;
	fwp_areq_t acmd_r, acmd_nxt;
	logic whole, wr_ok, stat_locked;
	logic [23:0] start;

	// ----------------------------------------------------------------
	// serial clock side
	// ----------------------------------------------------------------
	fwp_link u_link (
		.sck(SCK),
		.cs_n(CS_N),
		.si(SI),
		.nrst(NRST),
		.stat_in(stat_vec_r),
		.frame(frame),
		.frm_tgl(frm_tgl),
		.so(SO),
		.so_oe(SO_OE)
	);

	// ----------------------------------------------------------------
	// crossing of chip select, frame toggle and write-guard pin
	// ----------------------------------------------------------------
	// a bit changes only once the second and third stages agree
	always_comb begin
		agreed_nxt = ((sync2_r ~^ sync3_r) & sync3_r) | ((sync2_r ^ sync3_r) & agreed_r);
	end

	assign cs_q = agreed_r[0];
	assign tgl_q = agreed_r[1];
	assign wg_q = agreed_r[2];
	// the toggle crosses ahead of chip select, so a frame without edges is never replayed
	assign frame_end = cs_q && !cs_prev_r && (tgl_q != tgl_seen_r);

	always_comb begin
		cs_prev_nxt = cs_q;
		tgl_seen_nxt = (cs_q && !cs_prev_r) ? tgl_q : tgl_seen_r;
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			sync1_r <= 3'h5;
			sync2_r <= 3'h5;
			sync3_r <= 3'h5;
			agreed_r <= 3'h5;
			cs_prev_r <= 1'b1;
			tgl_seen_r <= 1'b0;
		end else if (CE) begin
			sync1_r <= {WG_N, frm_tgl, CS_N};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			agreed_r <= agreed_nxt;
			cs_prev_r <= cs_prev_nxt;
			tgl_seen_r <= tgl_seen_nxt;
		end
	end

	// ----------------------------------------------------------------
	// power-up write inhibit
	// ----------------------------------------------------------------
	always_comb begin
		inh_cnt_nxt = inh_cnt_r;
		inh_done_nxt = inh_done_r;
		if (!inh_done_r) begin
			inh_cnt_nxt = inh_cnt_r + 32'h00000001;
			inh_done_nxt = (inh_cnt_nxt >= PWR_INH_CYCLES);
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			inh_cnt_r <= 32'h00000000;
			inh_done_r <= 1'b0;
		end else if (CE) begin
			inh_cnt_r <= inh_cnt_nxt;
			inh_done_r <= inh_done_nxt;
		end
	end

	// ----------------------------------------------------------------
	// protection map
	// ----------------------------------------------------------------
	function automatic logic prot_hit(input logic [2:0] p, input logic [23:0] a);
		logic [23:0] lim;
		lim = 24'h000000;
		unique case (p)
			3'h1: lim = LIM_P1;
			3'h2: lim = LIM_P2;
			3'h3: lim = LIM_P3;
			3'h4: lim = LIM_P4;
			3'h5: lim = LIM_P5;
			3'h6: lim = LIM_P6;
			3'h7: lim = LIM_P7;
			3'h0: lim = 24'h000000;
		endcase
		// every range starts at zero, so the region start alone decides
		prot_hit = (p != 3'h0) && (a <= lim);
	endfunction

	// ----------------------------------------------------------------
	// command decode and status state
	// ----------------------------------------------------------------
	assign whole = (frame.bits[2:0] == 3'h0);
	assign wr_ok = whole && latch_r && inh_done_r;
	assign stat_locked = lock_r && !wg_q;

	always_comb begin
		state_nxt = state_r;
		latch_nxt = latch_r;
		lock_nxt = lock_r;
		prot_nxt = prot_r;
		busy_cnt_nxt = busy_cnt_r;
		areq_nxt = 1'b0;
		acmd_nxt = acmd_r;
		start = 24'h000000;
		unique case (state_r)
			ST_READY: begin
				if (frame_end) begin
					case (frame.op)
						OP_WR_ALLOW: begin
							if (whole && inh_done_r) begin
								latch_nxt = 1'b1;
							end
						end
						OP_WR_DENY: begin
							if (whole) begin
								latch_nxt = 1'b0;
							end
						end
						OP_STAT_WR: begin
							// lock clear means the guard pin does not matter
							if (wr_ok && frame.bits >= LEN_STAT_WR && !stat_locked) begin
								lock_nxt = frame.data[SB_LOCK];
								prot_nxt = frame.data[SB_PROT_HI:SB_PROT_LO];
								busy_cnt_nxt = STAT_WR_CYCLES;
								state_nxt = ST_BUSY;
							end
						end
						OP_PAGE_WR: begin
							start = frame.addr & MASK_PAGE;
							if (wr_ok && frame.bits >= LEN_PAGE_WR && !prot_hit(prot_r, start)) begin
								acmd_nxt = '{op: AOP_PAGE, addr: frame.addr, data: frame.data};
								areq_nxt = 1'b1;
								busy_cnt_nxt = PAGE_CYCLES;
								state_nxt = ST_BUSY;
							end
						end
						OP_SECT_WIPE: begin
							start = frame.addr & MASK_SECT;
							if (wr_ok && frame.bits >= LEN_ADDR && !prot_hit(prot_r, start)) begin
								acmd_nxt = '{op: AOP_SECT, addr: start, data: 8'hff};
								areq_nxt = 1'b1;
								busy_cnt_nxt = SECT_CYCLES;
								state_nxt = ST_BUSY;
							end
						end
						OP_BLK32_WIPE: begin
							start = frame.addr & MASK_BLK32;
							if (wr_ok && frame.bits >= LEN_ADDR && !prot_hit(prot_r, start)) begin
								acmd_nxt = '{op: AOP_BLK32, addr: start, data: 8'hff};
								areq_nxt = 1'b1;
								busy_cnt_nxt = BLK_CYCLES;
								state_nxt = ST_BUSY;
							end
						end
						OP_BLK64_WIPE: begin
							start = frame.addr & MASK_BLK64;
							if (wr_ok && frame.bits >= LEN_ADDR && !prot_hit(prot_r, start)) begin
								acmd_nxt = '{op: AOP_BLK64, addr: start, data: 8'hff};
								areq_nxt = 1'b1;
								busy_cnt_nxt = BLK_CYCLES;
								state_nxt = ST_BUSY;
							end
						end
						OP_CHIP_WIPE_A, OP_CHIP_WIPE_B: begin
							if (wr_ok && prot_r == 3'h0) begin
								acmd_nxt = '{op: AOP_CHIP, addr: 24'h000000, data: 8'hff};
								areq_nxt = 1'b1;
								busy_cnt_nxt = CHIP_CYCLES;
								state_nxt = ST_BUSY;
							end
						end
						OP_SLEEP: begin
							if (whole) begin
								state_nxt = ST_SLEEP;
							end
						end
						default: begin
						end
					endcase
				end
			end
			ST_BUSY: begin
				// frames ending now are dropped; status reads are served on the link side
				busy_cnt_nxt = busy_cnt_r - 32'h00000001;
				if (busy_cnt_r <= 32'h00000001) begin
					state_nxt = ST_READY;
					latch_nxt = 1'b0;
				end
			end
			ST_SLEEP: begin
				if (frame_end && frame.op == OP_WAKE) begin
					state_nxt = ST_READY;
				end
			end
		endcase
		stat_vec_nxt = {state_nxt == ST_SLEEP, lock_nxt, 2'b00, prot_nxt, latch_nxt, state_nxt == ST_BUSY};
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			state_r <= ST_READY;
			latch_r <= 1'b0;
			lock_r <= LOCK_RST;
			prot_r <= PROT_RST;
			busy_cnt_r <= 32'h00000000;
			areq_r <= 1'b0;
			acmd_r <= '{op: AOP_NONE, addr: 24'h000000, data: 8'h00};
			stat_vec_r <= 9'h000;
		end else if (CE) begin
			state_r <= state_nxt;
			latch_r <= latch_nxt;
			lock_r <= lock_nxt;
			prot_r <= prot_nxt;
			busy_cnt_r <= busy_cnt_nxt;
			areq_r <= areq_nxt;
			acmd_r <= acmd_nxt;
			stat_vec_r <= stat_vec_nxt;
		end
	end

	assign ARRAY_REQ = areq_r;
	assign ARRAY_CMD = acmd_r;

endmodule

// >>> tb/fwp_status_ctl_monitor.sv
// concurrent checks on the status control block, seen from its top ports only.
// assumes one control clock domain, MCLK, and the asynchronous active-low NRST.
module fwp_status_ctl_monitor import fwp_pkg::*; #(
	parameter int unsigned PWR_INH_CYCLES = PWR_INH_CYC
) (
	// control clock and power reset
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic CE,
	// serial link
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic SI,
	input wire logic WG_N,
	input wire logic SO,
	input wire logic SO_OE,
	// array request
	input wire logic ARRAY_REQ,
	input wire fwp_areq_t ARRAY_CMD
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!NRST);

	// CE-enabled cycles since power reset, saturating at the inhibit length
	int unsigned up_r;
	int unsigned up_nxt;
	always_comb begin
		up_nxt = up_r;
		if (CE && up_r < PWR_INH_CYCLES)
			up_nxt = up_r + 1;
	end
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST)
			up_r <= 0;
		else
			up_r <= up_nxt;
	end

	property p_req_alone;
		ARRAY_REQ |=> !ARRAY_REQ [*8];
	endproperty
	a_req_alone: assert property (p_req_alone) else $error("array request repeated during busy");
	property p_cmd_hold;
		!ARRAY_REQ |-> $stable(ARRAY_CMD);
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("array command moved without a request");
	property p_wipe_fill;
		ARRAY_REQ && ARRAY_CMD.op != AOP_PAGE |-> ARRAY_CMD.data == 8'hff;
	endproperty
	a_wipe_fill: assert property (p_wipe_fill) else $error("erase fill byte is not ff");
	property p_op_known;
		ARRAY_REQ |-> ARRAY_CMD.op != AOP_NONE && ARRAY_CMD.op <= AOP_CHIP;
	endproperty
	a_op_known: assert property (p_op_known) else $error("array request without a known operation");
	property p_sect_align;
		ARRAY_REQ && ARRAY_CMD.op == AOP_SECT |-> ARRAY_CMD.addr[11:0] == 12'h000;
	endproperty
	a_sect_align: assert property (p_sect_align) else $error("sector start not aligned");
	property p_chip_zero;
		ARRAY_REQ && ARRAY_CMD.op == AOP_CHIP |-> ARRAY_CMD.addr == 24'h000000;
	endproperty
	a_chip_zero: assert property (p_chip_zero) else $error("chip erase address not zero");
	property p_frame_end;
		ARRAY_REQ |-> CS_N && $past(CS_N, 3);
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("array request before the frame ended");
	property p_inhibit;
		ARRAY_REQ |-> up_r == PWR_INH_CYCLES;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("array request inside power-up inhibit");
	property p_quiet_out;
		CS_N |-> !SO_OE;
	endproperty
	a_quiet_out: assert property (p_quiet_out) else $error("serial output driven while deselected");
endmodule

bind fwp_status_ctl fwp_status_ctl_monitor #(.PWR_INH_CYCLES(PWR_INH_CYCLES)) mon_u (.MCLK(MCLK), .NRST(NRST),
	.CE(CE), .SCK(SCK), .CS_N(CS_N), .SI(SI), .WG_N(WG_N), .SO(SO), .SO_OE(SO_OE), .ARRAY_REQ(ARRAY_REQ),
	.ARRAY_CMD(ARRAY_CMD));

// >>> tb/fwp_spi_master.sv
// behavioural spi bus master, mode 0 or 3 by cpol, 80 ns serial clock only inside frames.
// assumes callers leave it idle between calls; gap after each frame is 100 ns.
module fwp_spi_master import fwp_pkg::*; (
	// link pins
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle level of the serial clock: 0 for mode 0, 1 for mode 3
	logic cpol = 1'b0;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// n bits of v, msb first; rd gathers the second byte off so
	task automatic xfer(input logic [47:0] v, input int n, output logic [7:0] rd);
		rd = 8'h00;
		// idle-level change lands before select; the 23 ns delay keeps edges off the control clock only for calls started on a clock edge
		sck = cpol;
		#23;
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			sck = 1'b0;
			si = v[47 - i];
			#40;
			sck = 1'b1;
			if (i >= 8 && i < 16)
				rd = {rd[6:0], so};
			#40;
		end
		sck = cpol;
		#10;
		cs_n = 1'b1;
		// released line must not keep looking valid
		si = ~si;
		#100;
	endtask
endmodule

// >>> tb/fwp_status_ctl_tb.sv
// self-checking bench: spi master model sends frames, array requests checked from a queue.
// assumes shortened inhibit and busy counts below; about 41k control cycles in all.
module fwp_status_ctl_tb import fwp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned PI = 400;
	localparam int unsigned BW = 1000;
	logic MCLK, NRST, CE, WG_N, SCK, CS_N, SI, SO, SO_OE, ARRAY_REQ;
	logic so_line;
	fwp_areq_t ARRAY_CMD;
	fwp_areq_t exp_q[$];
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	logic [7:0] st;
	logic [7:0] d;
	logic [23:0] a;
	logic [23:0] lim [8] = '{24'h0, LIM_P1, LIM_P2, LIM_P3, LIM_P4, LIM_P5, LIM_P6, LIM_P7};
	logic [7:0] ops [5] = '{OP_PAGE_WR, OP_BLK32_WIPE, OP_BLK64_WIPE, OP_CHIP_WIPE_A, OP_CHIP_WIPE_B};
	fwp_aop_t aops [5] = '{AOP_PAGE, AOP_BLK32, AOP_BLK64, AOP_CHIP, AOP_CHIP};
	logic [23:0] msk [5] = '{24'hffffff, MASK_BLK32, MASK_BLK64, 24'h0, 24'h0};

	fwp_status_ctl #(.PWR_INH_CYCLES(PI), .STAT_WR_CYCLES(BW), .PAGE_CYCLES(BW), .SECT_CYCLES(BW),
		.BLK_CYCLES(BW), .CHIP_CYCLES(BW)) dut_u (.MCLK(MCLK), .NRST(NRST), .CE(CE), .SCK(SCK), .CS_N(CS_N),
		.SI(SI), .WG_N(WG_N), .SO(SO), .SO_OE(SO_OE), .ARRAY_REQ(ARRAY_REQ), .ARRAY_CMD(ARRAY_CMD));
	// an undriven data line shows the inverse, so a read without output enable cannot pass
	assign so_line = SO_OE ? SO : ~SO;
	fwp_spi_master m_u (.sck(SCK), .cs_n(CS_N), .si(SI), .so(so_line));

	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end

	task automatic check(input string what, input logic [34:0] seen, input logic [34:0] expv);
		check_count++;
		if (seen !== expv) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, expv, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// request watcher and hang limit
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (ARRAY_REQ === 1'b1) begin
			if (exp_q.size() == 0)
				check("array request", 35'h1, 35'h0);
			else
				check("array command", ARRAY_CMD, exp_q.pop_front());
		end
		if (cyc == 90000) begin
			mismatches++;
			results();
		end
	end

	task automatic send(input logic [47:0] v, input int n);
		logic [7:0] r;
		m_u.xfer(v, n, r);
	endtask
	task automatic stat_is(input logic [7:0] e);
		logic [7:0] s;
		m_u.xfer({OP_STAT_RD, 40'h0}, 16, s);
		check("status", {27'h0, s}, {27'h0, e});
	endtask
	task automatic wait_ready();
		logic [7:0] s;
		int k;
		k = 0;
		do begin
			m_u.xfer({OP_STAT_RD, 40'h0}, 16, s);
			k++;
		end while (s[0] !== 1'b0 && k < 40);
		check("busy clear", {34'h0, s[0]}, 35'h0);
	endtask
	task automatic wr_stat(input logic [7:0] v);
		send({OP_WR_ALLOW, 40'h0}, 8);
		send({OP_STAT_WR, v, 32'h0}, 16);
	endtask
	task automatic erase(input logic [23:0] ad);
		send({OP_WR_ALLOW, 40'h0}, 8);
		send({OP_SECT_WIPE, ad, 16'h0}, 32);
	endtask

	initial begin
		NRST = 1'b0;
		CE = 1'b1;
		WG_N = 1'b1;
		a = 24'($urandom(29));
		repeat (20) @(posedge MCLK);
		NRST <= 1'b1;
		@(posedge MCLK);
		stat_is(8'h00);
		send({OP_WR_ALLOW, 40'h0}, 8);
		stat_is(8'h00);
		send({OP_SECT_WIPE, 24'h0, 16'h0}, 32);
		repeat (PI) @(posedge MCLK);
		send({OP_WR_ALLOW, 40'h0}, 9);
		stat_is(8'h00);
		send({OP_WR_ALLOW, 40'h0}, 8);
		stat_is(8'h02);
		send({OP_SECT_WIPE, 24'h0, 16'h0}, 36);
		stat_is(8'h02);
		send({OP_WR_DENY, 40'h0}, 8);
		stat_is(8'h00);
		// lock clear: guard pin has no say
		@(posedge MCLK) WG_N <= 1'b0;
		wr_stat(8'h97);
		stat_is(8'h97);
		wait_ready();
		stat_is(8'h94);
		wr_stat(8'h00);
		m_u.xfer({OP_STAT_RD, 40'h0}, 16, st);
		check("locked bits", {29'h0, st[7:2]}, 35'h25);
		@(posedge MCLK) WG_N <= 1'b1;
		wr_stat(8'h00);
		wait_ready();
		stat_is(8'h00);
		for (int p = 0; p < 8; p++) begin
			wr_stat({3'h0, p[2:0], 2'h0});
			wait_ready();
			if (p != 0) begin
				erase(24'($urandom_range(0, lim[p])));
				stat_is({3'h0, p[2:0], 2'h2});
			end
			if (p != 7) begin
				a = (p == 0) ? {4'h0, 20'($urandom)} : lim[p] + 24'h1;
				exp_q.push_back('{AOP_SECT, a & MASK_SECT, 8'hff});
				erase(a);
				wait_ready();
			end
		end
		wr_stat(8'h00);
		wait_ready();
		for (int i = 0; i < 5; i++) begin
			a = {4'h0, 20'($urandom)};
			d = 8'($urandom);
			send({OP_WR_ALLOW, 40'h0}, 8);
			exp_q.push_back('{aops[i], a & msk[i], (i == 0) ? d : 8'hff});
			send({ops[i], a, d, 8'h00}, 40);
			// a second copy while busy must not reach the array
			send({ops[i], a, d, 8'h00}, 40);
			stat_is(8'h03);
			wait_ready();
			stat_is(8'h00);
		end
		// the rest runs with the clock idling high
		m_u.cpol = 1'b1;
		send({OP_SLEEP, 40'h0}, 8);
		send({OP_WR_ALLOW, 40'h0}, 8);
		send({OP_WAKE, 40'h0}, 8);
		stat_is(8'h00);
		// frames seen while frozen are not acted on; work resumes afterwards
		@(posedge MCLK) CE <= 1'b0;
		send({OP_WR_ALLOW, 40'h0}, 8);
		stat_is(8'h00);
		@(posedge MCLK) CE <= 1'b1;
		send({OP_WR_ALLOW, 40'h0}, 8);
		stat_is(8'h02);
		@(posedge MCLK) NRST <= 1'b0;
		send({OP_WR_ALLOW, 40'h0}, 8);
		@(posedge MCLK) NRST <= 1'b1;
		stat_is(8'h00);
		check("pending requests", 35'(exp_q.size()), 35'h0);
		results();
	end
endmodule
